// ### scb_bridge.sv
// Behaviour
// R1: memory reads and high DMA request high priority
// R2: two or more inbound entries force high priority
// R3: lone entry waiting 16 cycles gets promoted
// R4: memory targets go over arbitrated memory-side bus
// R5: core peripheral traffic passes the outbound queue
// R6: outbound entries request and execute on peripheral bus
// R7: core read data returns through inbound queue
// R8: core peripheral reads split into request, return
// R9: register read return written to core register
// R10: external read return becomes register-side write
// R11: core read completes once request enters queue
// R12: dependent instruction held until return data written
// R13: full outbound queue stalls core
// R14: inbound writes pick memory or register bus by target
// R15: master reads return data via read-return buffer
// R16: master reads use memory bus unless register target
// R17: every queued request eventually serviced
// R18: software keeps peripheral accesses under eight per burst
// R19: peripheral-side queues carry 128-bit words
// R20: peripheral side runs at half core rate
// R21: all queues deliver in acceptance order
// R22: split read carries destination register tag
`default_nettype none

// -------------------------------------------------------------------
// in-order fifo
// -------------------------------------------------------------------
module scb_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_in_valid,
   input wire logic [W-1:0] i_in_data,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic [W-1:0] o_out_data,
   input wire logic i_out_ready,
   output logic [$clog2(D+1)-1:0] o_count
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);
   logic [W-1:0] mem_q [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [CW-1:0] cnt_q;
   wire push = i_in_valid && o_in_ready;
   wire pop = o_out_valid && i_out_ready;
   wire [AW-1:0] wr_nx = (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
   wire [AW-1:0] rd_nx = (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
   assign o_in_ready = (cnt_q != CW'(D));
   assign o_out_valid = (cnt_q != '0);
   assign o_out_data = mem_q[rd_q];
   assign o_count = cnt_q;
   // storage holds no reset; only valid slots are ever read
   always_ff @(posedge i_clk) begin
      if (i_ce && push) begin
         mem_q[wr_q] <= i_in_data;
      end
   end

   // single read and write pointers keep entries in order [R21]
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else if (i_ce) begin
         if (push) begin
            wr_q <= wr_nx;
         end
         if (pop) begin
            rd_q <= rd_nx;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule : scb_fifo

// -------------------------------------------------------------------
// bridge top
// -------------------------------------------------------------------
module scb_bridge import scb_pkg::*; #(
   parameter int OB_D = OB_DEPTH,
   parameter int IN_D = IN_DEPTH,
   parameter int RB_D = RB_DEPTH
) (
   input wire logic I_CLK,
   input wire logic I_RESETN,
   input wire logic I_CE,
   // core side
   input wire logic I_CORE_VALID,
   input wire logic I_CORE_WRITE,
   input wire logic [ADDR_W-1:0] I_CORE_ADDR,
   input wire logic [DATA_W-1:0] I_CORE_WDATA,
   input wire logic [TAG_W-1:0] I_CORE_DEST,
   output logic O_CORE_READY,
   input wire logic I_CORE_USE_VALID,
   input wire logic [TAG_W-1:0] I_CORE_USE_REG,
   output logic O_CORE_HOLD,
   // peripheral bus, outbound
   output logic O_PB_CLK_EN,
   output logic O_PB_REQ,
   input wire logic I_PB_GNT,
   output logic O_PB_WRITE,
   output logic [ADDR_W-1:0] O_PB_ADDR,
   output logic [DATA_W-1:0] O_PB_WDATA,
   output logic [TAG_W-1:0] O_PB_TAG,
   // peripheral bus, inbound
   input wire logic I_PB_IN_VALID,
   input wire logic [KIND_W-1:0] I_PB_IN_KIND,
   input wire logic I_PB_IN_HIPRI,
   input wire logic I_PB_IN_TOREG,
   input wire logic [TAG_W-1:0] I_PB_IN_TAG,
   input wire logic [ADDR_W-1:0] I_PB_IN_ADDR,
   input wire logic [DATA_W-1:0] I_PB_IN_DATA,
   output logic O_PB_IN_READY,
   // peripheral bus, read return
   output logic O_RB_VALID,
   output logic [DATA_W-1:0] O_RB_DATA,
   input wire logic I_RB_READY,
   // memory-side bus
   output logic O_MEM_REQ,
   output logic O_MEM_HIPRI,
   input wire logic I_MEM_GNT,
   output logic O_MEM_WRITE,
   output logic [ADDR_W-1:0] O_MEM_ADDR,
   output logic [DATA_W-1:0] O_MEM_WDATA,
   input wire logic I_MEM_RVALID,
   input wire logic [DATA_W-1:0] I_MEM_RDATA,
   // register-side bus
   output logic O_REG_REQ,
   input wire logic I_REG_GNT,
   output logic O_REG_WRITE,
   output logic [ADDR_W-1:0] O_REG_ADDR,
   output logic [DATA_W-1:0] O_REG_WDATA,
   input wire logic [DATA_W-1:0] I_REG_RDATA
);
   localparam int OCW = $clog2(OB_D + 1);
   localparam int ICW = $clog2(IN_D + 1);
   localparam int RCW = $clog2(RB_D + 1);
   // ---------------------------------------------------------------
   // half-rate peripheral tick
   // ---------------------------------------------------------------
   // one core clock, the peripheral side acts on every other edge,
   // so no crossing logic is needed between the two rates
   logic soc_tick_q;
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         soc_tick_q <= SOC_TICK_RESET;
      end else if (I_CE) begin
         soc_tick_q <= !soc_tick_q; // [R20]
      end
   end
   assign O_PB_CLK_EN = soc_tick_q;
   // ---------------------------------------------------------------
   // outbound queue
   // ---------------------------------------------------------------
   wire [OB_W-1:0] ob_in = {I_CORE_WRITE, I_CORE_DEST, I_CORE_ADDR, I_CORE_WDATA}; // [R22]
   wire [OB_W-1:0] ob_head;
   wire ob_ready;
   wire ob_valid;
   wire [OCW-1:0] ob_cnt;
   wire ob_issue = ob_valid && soc_tick_q && I_PB_GNT; // [R6]
   wire core_push = I_CORE_VALID && ob_ready;
   wire core_rd_push = core_push && !I_CORE_WRITE; // [R8]
   // all core peripheral traffic enters here; full stalls the core [R5] [R13]
   assign O_CORE_READY = ob_ready; // [R11]
   scb_fifo #(.W(OB_W), .D(OB_D)) u_core_outbound_queue (
      .i_clk(I_CLK),
      .i_resetn(I_RESETN),
      .i_ce(I_CE),
      .i_in_valid(I_CORE_VALID),
      .i_in_data(ob_in),
      .o_in_ready(ob_ready),
      .o_out_valid(ob_valid),
      .o_out_data(ob_head),
      .i_out_ready(ob_issue),
      .o_count(ob_cnt)
   );

   assign O_PB_REQ = ob_valid; // [R6]
   assign O_PB_WRITE = ob_head[OB_WR_BIT];
   assign O_PB_ADDR = ob_head[OB_ADDR_LSB +: ADDR_W];
   assign O_PB_WDATA = ob_head[OB_DATA_LSB +: DATA_W]; // [R19]
   assign O_PB_TAG = ob_head[OB_TAG_LSB +: TAG_W];
   // ---------------------------------------------------------------
   // inbound queue
   // ---------------------------------------------------------------
   wire [IN_W-1:0] in_entry = {I_PB_IN_KIND, I_PB_IN_HIPRI, I_PB_IN_TOREG, I_PB_IN_TAG,
                               I_PB_IN_ADDR, I_PB_IN_DATA};
   wire [IN_W-1:0] in_head;
   wire in_ready;
   wire in_valid;
   wire [ICW-1:0] in_cnt;
   wire in_pop;
   wire in_accept = I_PB_IN_VALID && soc_tick_q;
   assign O_PB_IN_READY = in_ready && soc_tick_q;
   scb_fifo #(.W(IN_W), .D(IN_D)) u_core_inbound_queue (
      .i_clk(I_CLK),
      .i_resetn(I_RESETN),
      .i_ce(I_CE),
      .i_in_valid(in_accept),
      .i_in_data(in_entry),
      .o_in_ready(in_ready),
      .o_out_valid(in_valid),
      .o_out_data(in_head),
      .i_out_ready(in_pop),
      .o_count(in_cnt)
   );

   wire [KIND_W-1:0] hd_kind = in_head[IN_KIND_LSB +: KIND_W];
   wire hd_hipri = in_head[IN_HIPRI_BIT];
   wire hd_toreg = in_head[IN_TOREG_BIT];
   wire [TAG_W-1:0] hd_tag = in_head[IN_TAG_LSB +: TAG_W];
   wire [ADDR_W-1:0] hd_addr = in_head[IN_ADDR_LSB +: ADDR_W];
   wire [DATA_W-1:0] hd_data = in_head[IN_DATA_LSB +: DATA_W];
   wire hd_ret = (hd_kind == KIND_RET);
   wire hd_rd = (hd_kind == KIND_MRD);
   // returned core read data always lands in a core register [R7] [R10]
   wire hd_use_reg = hd_ret || hd_toreg; // [R14] [R16]
   // ---------------------------------------------------------------
   // read-return buffer
   // ---------------------------------------------------------------
   wire rb_push;
   wire rb_ready;
   wire [DATA_W-1:0] rb_data_in;
   wire rb_valid;
   wire rb_pop = rb_valid && soc_tick_q && I_RB_READY;
   scb_fifo #(.W(DATA_W), .D(RB_D)) u_read_return_buffer (
      .i_clk(I_CLK),
      .i_resetn(I_RESETN),
      .i_ce(I_CE),
      .i_in_valid(rb_push),
      .i_in_data(rb_data_in),
      .o_in_ready(rb_ready),
      .o_out_valid(rb_valid),
      .o_out_data(O_RB_DATA),
      .i_out_ready(rb_pop),
      .o_count()
   );
   assign O_RB_VALID = rb_valid && soc_tick_q; // [R15]
   // ---------------------------------------------------------------
   // inbound execution
   // ---------------------------------------------------------------
   scb_state_e state_q;
   scb_state_e state_d;
   // a master read only starts when the return buffer has room, so
   // the data it brings back can never be dropped
   wire can_go = in_valid && (state_q == ST_IDLE) && (!hd_rd || rb_ready);
   wire bus_gnt = hd_use_reg ? I_REG_GNT : I_MEM_GNT;
   wire granted = can_go && bus_gnt;
   assign O_MEM_REQ = can_go && !hd_use_reg; // [R4]
   assign O_REG_REQ = can_go && hd_use_reg; // [R9]
   assign O_MEM_WRITE = !hd_rd;
   assign O_MEM_ADDR = hd_addr;
   assign O_MEM_WDATA = hd_data;
   assign O_REG_WRITE = !hd_rd;
   assign O_REG_ADDR = hd_ret ? ADDR_W'(hd_tag) : hd_addr; // [R22]
   assign O_REG_WDATA = hd_data;
   wire mem_rd_done = (state_q == ST_RDWAIT) && I_MEM_RVALID;
   assign rb_push = (granted && hd_rd && hd_use_reg) || mem_rd_done; // [R15]
   assign rb_data_in = mem_rd_done ? I_MEM_RDATA : I_REG_RDATA;
   assign in_pop = (granted && !(hd_rd && !hd_use_reg)) || mem_rd_done;
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (granted && hd_rd && !hd_use_reg) begin
               state_d = ST_RDWAIT;
            end
         end
         ST_RDWAIT: begin
            if (I_MEM_RVALID) begin
               state_d = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         state_q <= ST_IDLE;
      end else if (I_CE) begin
         state_q <= state_d;
      end
   end

   // ---------------------------------------------------------------
   // memory-side priority
   // ---------------------------------------------------------------
   logic [AGE_W-1:0] age_q;
   wire aged = (age_q >= AGE_LIMIT);
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         age_q <= AGE_RESET;
      end else if (I_CE) begin
         if (!in_valid || in_pop) begin
            age_q <= AGE_RESET;
         end else if (!aged) begin
            age_q <= age_q + 1'b1; // [R3]
         end
      end
   end

   // promotion by age keeps a lone entry from starving behind the core [R17]
   assign O_MEM_HIPRI = O_MEM_REQ && (hd_rd || hd_hipri // [R1]
                        || (in_cnt >= ICW'(IN_HI_COUNT)) // [R2]
                        || aged); // [R3]

   // ---------------------------------------------------------------
   // split read scoreboard
   // ---------------------------------------------------------------
   logic [NUM_TAGS-1:0] pend_q;
   wire ret_done = granted && hd_ret;
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         pend_q <= '0;
      end else if (I_CE) begin
         for (int i = 0; i < NUM_TAGS; i++) begin
            // a new request wins over a return to the same register
            if (core_rd_push && (I_CORE_DEST == TAG_W'(i))) begin
               pend_q[i] <= 1'b1; // [R8]
            end else if (ret_done && (hd_tag == TAG_W'(i))) begin
               pend_q[i] <= 1'b0; // [R12]
            end
         end
      end
   end
   assign O_CORE_HOLD = I_CORE_USE_VALID && pend_q[I_CORE_USE_REG]; // [R12]
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RESETN);

   mem_read_hi_a: assert property (O_MEM_REQ && hd_rd |-> O_MEM_HIPRI) // [R1]
      else $error("memory read not high priority");
   two_entry_hi_a: assert property (O_MEM_REQ && in_cnt >= ICW'(2) |-> O_MEM_HIPRI) // [R2]
      else $error("two inbound entries not high priority");
   age_promote_a: assert property (age_q == AGE_LIMIT && O_MEM_REQ |-> O_MEM_HIPRI) // [R3]
      else $error("aged entry not promoted");
   full_stall_a: assert property (ob_cnt == OCW'(OB_D) |-> !O_CORE_READY) // [R13]
      else $error("core accepted into full outbound queue");
   dep_hold_a: assert property (
      I_CE && core_rd_push ##1 (I_CORE_USE_VALID && I_CORE_USE_REG == $past(I_CORE_DEST))
      |-> O_CORE_HOLD) // [R12]
      else $error("dependent instruction not held");
   bus_exclusive_a: assert property (!(O_MEM_REQ && O_REG_REQ)) // [R14]
      else $error("both internal buses requested");
   half_rate_a: assert property ((I_CE && soc_tick_q) ##1 I_CE |-> !soc_tick_q) // [R20]
      else $error("peripheral tick not half rate");
   pb_issue_a: assert property (
      I_CE && ob_issue && !core_push |=> ob_cnt == $past(ob_cnt) - OCW'(1)) // [R6]
      else $error("issued outbound entry not removed");
   rd_wait_quiet_a: assert property (state_q == ST_RDWAIT |-> !O_MEM_REQ && !O_REG_REQ) // [R15]
      else $error("bus requested while awaiting read data");
endmodule : scb_bridge
`default_nettype wire

// ### scb_bridge_tb_top.sv
`default_nettype none
module scb_bridge_tb_top import scb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, stall = 1'b1, rb_ready = 1'b0;
   logic core_valid = 1'b0, core_write = 1'b0, core_use_valid = 1'b0;
   logic [ADDR_W-1:0] core_addr = 32'h0, pb_in_addr = 32'h0;
   logic [DATA_W-1:0] core_wdata = 128'h0, pb_in_data = 128'h0;
   logic [TAG_W-1:0] core_dest = 6'h0, core_use_reg = 6'h0, pb_in_tag = 6'h0;
   logic pb_in_valid = 1'b0, pb_in_hipri = 1'b0, pb_in_toreg = 1'b0;
   logic [KIND_W-1:0] pb_in_kind = 2'h0;
   logic core_ready, core_hold, pb_clk_en, pb_req, pb_gnt, pb_write, pb_in_ready, rb_valid;
   logic mem_req, mem_hipri, mem_gnt, mem_write, mem_rvalid, reg_req, reg_gnt, reg_write;
   logic [ADDR_W-1:0] pb_addr, mem_addr, reg_addr;
   logic [DATA_W-1:0] pb_wdata, rb_data, mem_wdata, mem_rdata, reg_wdata, reg_rdata;
   logic [TAG_W-1:0] pb_tag;
   int n_mismatch = 0;
   int compares = 0;
   always #10 clk = ~clk;
   scb_bridge u_scb_bridge (
      .I_CLK(clk), .I_RESETN(resetn), .I_CE(ce),
      .I_CORE_VALID(core_valid), .I_CORE_WRITE(core_write), .I_CORE_ADDR(core_addr),
      .I_CORE_WDATA(core_wdata), .I_CORE_DEST(core_dest), .O_CORE_READY(core_ready),
      .I_CORE_USE_VALID(core_use_valid), .I_CORE_USE_REG(core_use_reg), .O_CORE_HOLD(core_hold),
      .O_PB_CLK_EN(pb_clk_en), .O_PB_REQ(pb_req), .I_PB_GNT(pb_gnt), .O_PB_WRITE(pb_write),
      .O_PB_ADDR(pb_addr), .O_PB_WDATA(pb_wdata), .O_PB_TAG(pb_tag),
      .I_PB_IN_VALID(pb_in_valid), .I_PB_IN_KIND(pb_in_kind), .I_PB_IN_HIPRI(pb_in_hipri),
      .I_PB_IN_TOREG(pb_in_toreg), .I_PB_IN_TAG(pb_in_tag), .I_PB_IN_ADDR(pb_in_addr),
      .I_PB_IN_DATA(pb_in_data), .O_PB_IN_READY(pb_in_ready),
      .O_RB_VALID(rb_valid), .O_RB_DATA(rb_data), .I_RB_READY(rb_ready),
      .O_MEM_REQ(mem_req), .O_MEM_HIPRI(mem_hipri), .I_MEM_GNT(mem_gnt), .O_MEM_WRITE(mem_write),
      .O_MEM_ADDR(mem_addr), .O_MEM_WDATA(mem_wdata), .I_MEM_RVALID(mem_rvalid),
      .I_MEM_RDATA(mem_rdata), .O_REG_REQ(reg_req), .I_REG_GNT(reg_gnt), .O_REG_WRITE(reg_write),
      .O_REG_ADDR(reg_addr), .O_REG_WDATA(reg_wdata), .I_REG_RDATA(reg_rdata));
   scb_far_model u_scb_far_model (
      .i_clk(clk), .i_resetn(resetn), .i_stall(stall), .i_pb_req(pb_req), .o_pb_gnt(pb_gnt),
      .i_mem_req(mem_req), .i_mem_write(mem_write), .i_mem_addr(mem_addr),
      .o_mem_gnt(mem_gnt), .o_mem_rvalid(mem_rvalid), .o_mem_rdata(mem_rdata),
      .i_reg_req(reg_req), .i_reg_addr(reg_addr), .o_reg_gnt(reg_gnt), .o_reg_rdata(reg_rdata));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk_bit(input logic exp, input logic act);
      compares++;
      if (act !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t exp=%h act=%h", $time, exp, act);
      end
   endtask : chk_bit
   task automatic chk_word(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] act);
      compares++;
      if (act !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t exp=%h act=%h", $time, exp, act);
      end
   endtask : chk_word
   function automatic logic cond(input int s);
      case (s)
         0: return core_ready;
         1: return pb_in_ready;
         2: return pb_req;
         3: return pb_req && pb_gnt && pb_clk_en;
         4: return mem_req;
         5: return reg_req;
         6: return rb_valid;
         7: return !core_hold;
         default: return !mem_req;
      endcase
   endfunction : cond
   // bounded wait, sampled at the falling edge where outputs are settled
   task automatic wait_for(input int s);
      for (int k = 0; k < 300; k++) begin
         @(negedge clk);
         if (cond(s) === 1'b1) return;
      end
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h act=%h", $time, 1'b1, 1'b0);
   endtask : wait_for
   task automatic in_push(input logic [1:0] kind, input logic hi, input logic toreg,
                          input logic [5:0] tag, input logic [31:0] addr, input logic [127:0] d);
      @(posedge clk);
      pb_in_valid <= 1'b1;
      pb_in_kind <= kind;
      pb_in_hipri <= hi;
      pb_in_toreg <= toreg;
      pb_in_tag <= tag;
      pb_in_addr <= addr;
      pb_in_data <= d;
      wait_for(1);
      @(posedge clk);
      pb_in_valid <= 1'b0;
   endtask : in_push
   task automatic end_of_test();
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_fill();
      @(posedge clk);
      core_valid <= 1'b1;
      core_write <= 1'b1;
      for (int i = 0; i < OB_DEPTH; i++) begin
         core_addr <= 32'h100 + 32'(i);
         core_wdata <= {4{8'(i), 24'hc0ffee}};
         wait_for(0);
         @(posedge clk);
      end
      repeat (4) @(negedge clk);
      chk_bit(1'b0, core_ready);
      chk_bit(1'b1, pb_req);
      @(posedge clk);
      core_valid <= 1'b0;
      stall <= 1'b0;
      for (int i = 0; i < OB_DEPTH; i++) begin
         wait_for(3);
         chk_bit(1'b1, pb_write);
         chk_word({96'h0, 32'h100 + 32'(i)}, {96'h0, pb_addr});
         chk_word({4{8'(i), 24'hc0ffee}}, pb_wdata);
         @(posedge clk);
      end
      $display("test fill done");
   endtask : t_fill
   task automatic t_split();
      @(posedge clk);
      core_valid <= 1'b1;
      core_write <= 1'b0;
      core_addr <= 32'h200;
      core_dest <= 6'h2a;
      core_use_valid <= 1'b1;
      core_use_reg <= 6'h2a;
      @(negedge clk);
      chk_bit(1'b1, core_ready);
      @(posedge clk);
      core_valid <= 1'b0;
      wait_for(2);
      chk_bit(1'b0, pb_write);
      chk_word({122'h0, 6'h2a}, {122'h0, pb_tag});
      chk_bit(1'b1, core_hold);
      in_push(KIND_RET, 1'b0, 1'b1, 6'h2a, 32'h200, {4{32'h5eed_0001}});
      wait_for(5);
      chk_bit(1'b1, reg_write);
      chk_word({122'h0, 6'h2a}, {96'h0, reg_addr});
      chk_word({4{32'h5eed_0001}}, reg_wdata);
      chk_bit(1'b1, core_hold);
      wait_for(7);
      chk_bit(1'b0, core_hold);
      $display("test split done");
   endtask : t_split
   task automatic t_prio();
      stall <= 1'b1;
      in_push(KIND_MWR, 1'b1, 1'b0, 6'h0, 32'h300, {4{32'h0d0a_0001}});
      wait_for(4);
      chk_bit(1'b1, mem_hipri);
      stall <= 1'b0;
      wait_for(8);
      stall <= 1'b1;
      in_push(KIND_MWR, 1'b0, 1'b0, 6'h0, 32'h304, {4{32'h0d0a_0002}});
      wait_for(4);
      chk_bit(1'b1, mem_write);
      chk_word({96'h0, 32'h304}, {96'h0, mem_addr});
      chk_word({4{32'h0d0a_0002}}, mem_wdata);
      // fifteen waited cycles stay low, the sixteenth promotes
      repeat (15) @(negedge clk);
      chk_bit(1'b0, mem_hipri);
      @(negedge clk);
      chk_bit(1'b1, mem_hipri);
      stall <= 1'b0;
      wait_for(8);
      stall <= 1'b1;
      in_push(KIND_MWR, 1'b0, 1'b0, 6'h0, 32'h308, {4{32'h0d0a_0003}});
      wait_for(4);
      chk_bit(1'b0, mem_hipri);
      in_push(KIND_MWR, 1'b0, 1'b0, 6'h0, 32'h30c, {4{32'h0d0a_0004}});
      @(negedge clk);
      chk_bit(1'b1, mem_hipri);
      stall <= 1'b0;
      wait_for(8);
      $display("test priority done");
   endtask : t_prio
   task automatic t_mread();
      in_push(KIND_MWR, 1'b0, 1'b1, 6'h0, 32'h44, {4{32'h0d0a_0005}});
      wait_for(5);
      chk_bit(1'b1, reg_write);
      chk_word({96'h0, 32'h44}, {96'h0, reg_addr});
      chk_word({4{32'h0d0a_0005}}, reg_wdata);
      in_push(KIND_MRD, 1'b0, 1'b0, 6'h0, 32'h400, {4{32'h0}});
      wait_for(4);
      chk_bit(1'b0, mem_write);
      chk_bit(1'b0, reg_req);
      chk_word({96'h0, 32'h400}, {96'h0, mem_addr});
      chk_bit(1'b1, mem_hipri);
      in_push(KIND_MRD, 1'b0, 1'b1, 6'h0, 32'h41, {4{32'h0}});
      wait_for(5);
      chk_bit(1'b0, reg_write);
      chk_bit(1'b0, mem_req);
      chk_word({96'h0, 32'h41}, {96'h0, reg_addr});
      @(posedge clk);
      rb_ready <= 1'b1;
      wait_for(6);
      chk_word({4{32'h400 ^ 32'h0f0f_0000}}, rb_data);
      @(posedge clk);
      wait_for(6);
      chk_word({4{32'h41 ^ 32'h5a5a_0000}}, rb_data);
      @(posedge clk);
      rb_ready <= 1'b0;
      @(negedge clk);
      chk_bit(1'b0, rb_valid);
      $display("test master read done");
   endtask : t_mread
   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(negedge clk);
      chk_bit(1'b0, pb_in_ready);
      chk_bit(1'b0, mem_req);
      chk_bit(1'b1, core_ready);
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(negedge clk);
      chk_bit(1'b1, pb_clk_en);
      @(negedge clk);
      chk_bit(1'b0, pb_clk_en);
      // a low clock enable must freeze the peripheral tick
      @(posedge clk);
      ce <= 1'b0;
      repeat (2) @(negedge clk);
      chk_bit(1'b1, pb_clk_en);
      @(posedge clk);
      ce <= 1'b1;
      t_fill();
      t_split();
      t_prio();
      t_mread();
      end_of_test();
   end
   // the whole run needs well under a thousand cycles
   initial begin
      #100us;
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h act=%h", $time, 1'b1, 1'b0);
      end_of_test();
   end
endmodule : scb_bridge_tb_top
`default_nettype wire

// ### scb_far_model.sv
`default_nettype none
module scb_far_model
   import scb_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_stall,
   input wire logic i_pb_req,
   output logic o_pb_gnt,
   input wire logic i_mem_req,
   input wire logic i_mem_write,
   input wire logic [ADDR_W-1:0] i_mem_addr,
   output logic o_mem_gnt,
   output logic o_mem_rvalid,
   output logic [DATA_W-1:0] o_mem_rdata,
   input wire logic i_reg_req,
   input wire logic [ADDR_W-1:0] i_reg_addr,
   output logic o_reg_gnt,
   output logic [DATA_W-1:0] o_reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // grants and read return
   // ---------------------------------------------------------------
   // grants lag requests by a cycle, so a request waits at least once unless the one before it was granted in the cycle just past
   logic [1:0] rd_wait_q;
   logic [ADDR_W-1:0] rd_addr_q;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_pb_gnt <= 1'b0;
         o_mem_gnt <= 1'b0;
         o_reg_gnt <= 1'b0;
         o_mem_rvalid <= 1'b0;
         rd_wait_q <= 2'h0;
         rd_addr_q <= 32'h0;
         o_mem_rdata <= 128'h0;
         o_reg_rdata <= 128'h0;
      end else begin
         o_pb_gnt <= i_pb_req && !i_stall;
         o_mem_gnt <= i_mem_req && !i_stall;
         o_reg_gnt <= i_reg_req && !i_stall;
         if (o_mem_gnt && i_mem_req && !i_mem_write) begin
            rd_wait_q <= 2'h3;
            rd_addr_q <= i_mem_addr;
         end else if (rd_wait_q != 2'h0) begin
            rd_wait_q <= rd_wait_q - 2'h1;
         end
         o_mem_rvalid <= (rd_wait_q == 2'h1);
         // idle data lines keep flipping so a stale sample never matches
         o_mem_rdata <= (rd_wait_q == 2'h1) ? {4{rd_addr_q ^ 32'h0f0f_0000}} : ~o_mem_rdata;
         o_reg_rdata <= i_reg_req ? {4{i_reg_addr ^ 32'h5a5a_0000}} : ~o_reg_rdata;
      end
   end
endmodule : scb_far_model
`default_nettype wire

// ### scb_pkg.sv
`default_nettype none
package scb_pkg;
   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int DATA_W = 128;
   localparam int ADDR_W = 32;
   localparam int TAG_W = 6;
   localparam int KIND_W = 2;
   localparam int NUM_TAGS = 64;
   // ---------------------------------------------------------------
   // queue depths
   // ---------------------------------------------------------------
   localparam int OB_DEPTH = 8;
   localparam int IN_DEPTH = 8;
   localparam int RB_DEPTH = 8;
   // ---------------------------------------------------------------
   // outbound entry layout: {write, tag, addr, data}
   // ---------------------------------------------------------------
   localparam int OB_DATA_LSB = 0;
   localparam int OB_ADDR_LSB = 128;
   localparam int OB_TAG_LSB = 160;
   localparam int OB_WR_BIT = 166;
   localparam int OB_W = 167;
   // ---------------------------------------------------------------
   // inbound entry layout: {kind, hipri, toreg, tag, addr, data}
   // ---------------------------------------------------------------
   localparam int IN_DATA_LSB = 0;
   localparam int IN_ADDR_LSB = 128;
   localparam int IN_TAG_LSB = 160;
   localparam int IN_TOREG_BIT = 166;
   localparam int IN_HIPRI_BIT = 167;
   localparam int IN_KIND_LSB = 168;
   localparam int IN_W = 170;
   // ---------------------------------------------------------------
   // inbound transaction kinds
   // ---------------------------------------------------------------
   localparam logic [1:0] KIND_RET = 2'h0;
   localparam logic [1:0] KIND_MWR = 2'h1;
   localparam logic [1:0] KIND_MRD = 2'h2;
   // ---------------------------------------------------------------
   // priority promotion
   // ---------------------------------------------------------------
   localparam int IN_HI_COUNT = 2;
   localparam int IN_AGE_CYC = 16;
   localparam int AGE_W = 5;
   localparam logic [AGE_W-1:0] AGE_LIMIT = 5'h10;
   localparam logic [AGE_W-1:0] AGE_RESET = 5'h00;
   localparam logic SOC_TICK_RESET = 1'b0;
   // ---------------------------------------------------------------
   // inbound execution states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RDWAIT = 2'h1
   } scb_state_e;
endpackage : scb_pkg
`default_nettype wire
